// file: fsa_alert_top.sv
/*
  fsa_alert_top: fault and warning status latch, alert pin drive, and a
  small bus responder on the serial clock for the alert response read,
  the clear-faults send byte and the output on/off byte write.
  Assumes analog inputs are asynchronous levels, converter samples and
  configuration writes come on ref_clk, and sda_in is launched by the
  far end relative to scl so it is taken on scl edges only.
*/
`timescale 1ns/1ps
module fsa_alert_top (
  // core clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  // serial link clock and data
  input  wire logic               scl,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  // address strap
  input  wire logic [6:0]         own_addr,
  // analog protection levels, asynchronous
  input  wire logic               uv_fault_in,
  input  wire logic               ov_fault_in,
  input  wire logic               oc_timeout_in,
  input  wire logic               hs_timer_active_in,
  input  wire logic               fet_health_bad_in,
  // converter samples and configuration, on ref_clk
  input  wire fsa_pkg::fsa_sample_t sample,
  input  wire fsa_pkg::fsa_cfg_t  cfg,
  input  wire logic               has_vout_sense,
  input  wire logic               warn2_over,
  input  wire logic               alert1_invert,
  input  wire logic               alert2_invert,
  // alert pins, open drain
  output logic                    alert1_out,
  output logic                    alert1_oe,
  output logic                    alert2_out,
  output logic                    alert2_oe,
  // switch and status
  output logic                    hs_enable,
  output logic [15:0]             status
);

  typedef struct packed {
    logic [15:0]      status;
    logic [15:0]      en1;
    logic [15:0]      en2;
    logic [5:0][11:0] lim;
    logic             a1;
    logic             a2;
    logic             hs_off;
    logic             hs_en;
    logic             op_prev;
    logic [2:0]       tgl_prev;
    logic             a1_oe;
    logic             a2_oe;
    logic             pin_lvl;
    logic             pend;
  } fsa_core_t;

  typedef struct packed {
    fsa_pkg::fsa_lstate_t st;
    logic [2:0]           cnt;
    logic [7:0]           sh;
    logic [7:0]           tx;
    logic                 is_ara;
    logic                 is_op;
    logic                 sda_oe;
    logic                 win_t;
    logic                 clr_t;
    logic                 cml_t;
    logic                 op_on;
  } fsa_link_t;

  fsa_core_t c_reg;
  fsa_core_t c_next;
  fsa_link_t l_reg;
  fsa_link_t l_next;
  logic      lsda_reg;

  // synchronised signals
  logic [4:0]  lvl_s;
  logic [3:0]  lnk_s;
  logic        pend_s;
  logic [6:0]  addr_s;
  logic        lrst_n;

  // core decode wires
  logic [15:0] set_vec;
  logic [15:0] st_next;
  logic [15:0] rise;
  logic        win_evt;
  logic        clr_cmd;
  logic        cml_evt;
  logic        op_rise;
  logic        clr_evt;
  logic        rel_evt;
  logic        fault_any;
  logic [3:0]  ovr;
  logic [3:0]  und;
  logic [11:0] w2_hi;
  logic [11:0] w2_lo;

  // link decode wires
  logic        l_start;
  logic        l_stop;
  logic [7:0]  l_byte;

  function automatic logic chan_hit(input fsa_pkg::fsa_sample_t s,
                                    input logic [1:0] ch);
    chan_hit = s.valid && (s.chan == ch);
  endfunction

  // analog levels cross into ref_clk before anything reads them
  fsa_sync #(.W(5), .INIT(5'h00)) u_lvl_sync (
    .clk   (ref_clk),
    .rst_n (reset_n),
    .d     ({fet_health_bad_in, hs_timer_active_in, oc_timeout_in,
             ov_fault_in, uv_fault_in}),
    .q     (lvl_s)
  );

  // link toggles and the on level come across as levels
  fsa_sync #(.W(4), .INIT({fsa_pkg::OP_RST, 3'h0})) u_lnk_sync (
    .clk   (ref_clk),
    .rst_n (reset_n),
    .d     ({l_reg.op_on, l_reg.cml_t, l_reg.clr_t, l_reg.win_t}),
    .q     (lnk_s)
  );

  // alert pending and the strap go the other way, onto scl
  fsa_sync #(.W(8), .INIT(8'h00)) u_to_link (
    .clk   (scl),
    .rst_n (reset_n),
    .d     ({c_reg.pend, own_addr}),
    .q     ({pend_s, addr_s})
  );

  // link reset releases on scl so the responder never sees a torn edge
  fsa_sync #(.W(1), .INIT(1'b0)) u_lrst (
    .clk   (scl),
    .rst_n (reset_n),
    .d     (1'b1),
    .q     (lrst_n)
  );

  // second current threshold flips between over and under compare
  assign w2_hi = warn2_over ? c_reg.lim[fsa_pkg::L_IOUT_W2]
                            : fsa_pkg::LIM_FULL;
  assign w2_lo = warn2_over ? fsa_pkg::LIM_ZERO
                            : c_reg.lim[fsa_pkg::L_IOUT_W2];

  // one comparator per sampled channel, the last is the second threshold
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_cmp
      localparam logic [1:0] CH = (gi == 0) ? fsa_pkg::CH_VIN  :
                                  (gi == 1) ? fsa_pkg::CH_VOUT :
                                              fsa_pkg::CH_IOUT;
      fsa_cmp u_cmp (
        .valid (chan_hit(sample, CH)),
        .code  (sample.code),
        .hi    ((gi == 3) ? w2_hi : c_reg.lim[2 * (gi % 3)]),
        .lo    ((gi == 3) ? w2_lo :
                (gi == 2) ? fsa_pkg::LIM_ZERO : c_reg.lim[2 * (gi % 3) + 1]),
        .over  (ovr[gi]),
        .under (und[gi])
      );
    end
  endgenerate

  // event pulses from the link toggles and the on level, plus the fault summary
  always_comb
  begin
    win_evt   = lnk_s[0] ^ c_reg.tgl_prev[0];
    clr_cmd   = lnk_s[1] ^ c_reg.tgl_prev[1];
    cml_evt   = lnk_s[2] ^ c_reg.tgl_prev[2];
    op_rise   = lnk_s[3] & ~c_reg.op_prev;
    clr_evt   = clr_cmd | op_rise;
    rel_evt   = clr_evt | win_evt;
    fault_any = lvl_s[0] | lvl_s[1] | lvl_s[2];
  end

  // set sources; levels are re-applied every cycle so a clear keeps them
  always_comb
  begin
    set_vec                     = 16'h0000;
    set_vec[fsa_pkg::B_UV]      = lvl_s[0];
    set_vec[fsa_pkg::B_OV]      = lvl_s[1];
    set_vec[fsa_pkg::B_OC]      = lvl_s[2];
    set_vec[fsa_pkg::B_CURRENT_REGULATION_ACTIVE_WARNING]    = lvl_s[3];
    set_vec[fsa_pkg::B_FET_BAD] = lvl_s[4];
    set_vec[fsa_pkg::B_CML]     = cml_evt;
    set_vec[fsa_pkg::B_VIN_OV]  = ovr[0];
    set_vec[fsa_pkg::B_VIN_UV]  = und[0];
    set_vec[fsa_pkg::B_VOUT_OV] = ovr[1] & has_vout_sense;
    set_vec[fsa_pkg::B_VOUT_UV] = und[1] & has_vout_sense;
    set_vec[fsa_pkg::B_IOUT_OC] = ovr[2];
    set_vec[fsa_pkg::B_IOUT_W2] = ovr[3] | und[3];
  end

  // status latch: clear first, then or in sets so a set wins
  always_comb
  begin
    st_next = (clr_evt ? 16'h0000 : c_reg.status)
              | set_vec;
    rise    = st_next & ~c_reg.status;
  end

  // core state update
  always_comb
  begin
    c_next          = c_reg;
    c_next.status   = st_next;
    c_next.tgl_prev = lnk_s[2:0];
    c_next.op_prev  = lnk_s[3];
    // configuration writes; limits only take the low twelve bits
    if (cfg.wr)
    begin
      if (cfg.sel == fsa_pkg::SEL_EN1)
        c_next.en1 = cfg.data;
      else if (cfg.sel == fsa_pkg::SEL_EN2)
        c_next.en2 = cfg.data;
      else
        c_next.lim[cfg.sel - fsa_pkg::SEL_LIM0] = cfg.data[11:0];
    end
    // a fault latches the switch off until an off then on cycle
    c_next.hs_off = fault_any | (c_reg.hs_off & ~op_rise);
    // warnings never reach the switch
    c_next.hs_en  = lnk_s[3] & ~c_next.hs_off;
    // each pin rises on its own enabled edge, both drop together
    c_next.a1 = (|(rise & c_reg.en1))
                | (c_reg.a1 & ~rel_evt);
    c_next.a2 = (|(rise & c_reg.en2))
                | (c_reg.a2 & ~rel_evt);
    // inversion turns the idle level into the driven one
    c_next.a1_oe   = c_next.a1 ^ alert1_invert;
    c_next.a2_oe   = c_next.a2 ^ alert2_invert;
    c_next.pin_lvl = 1'b0;
    c_next.pend    = c_next.a1 | c_next.a2;
  end

  // core registers; limits power up so no threshold can trip, except the second current threshold in over compare
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      c_reg          <= '0;
      c_reg.status   <= fsa_pkg::STAT_RST;
      c_reg.en1      <= fsa_pkg::EN1_RST;
      c_reg.en2      <= fsa_pkg::EN2_RST;
      c_reg.lim[fsa_pkg::L_VIN_OV]  <= fsa_pkg::LIM_FULL;
      c_reg.lim[fsa_pkg::L_VIN_UV]  <= fsa_pkg::LIM_ZERO;
      c_reg.lim[fsa_pkg::L_VOUT_OV] <= fsa_pkg::LIM_FULL;
      c_reg.lim[fsa_pkg::L_VOUT_UV] <= fsa_pkg::LIM_ZERO;
      c_reg.lim[fsa_pkg::L_IOUT_OC] <= fsa_pkg::LIM_FULL;
      c_reg.lim[fsa_pkg::L_IOUT_W2] <= fsa_pkg::LIM_ZERO;
      c_reg.op_prev  <= fsa_pkg::OP_RST;
      c_reg.a1_oe    <= 1'b0;
      c_reg.a2_oe    <= 1'b0;
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  // sda is taken while scl is high; the fsm compares it at the fall
  always_ff @(posedge scl or negedge lrst_n)
  begin
    if (!lrst_n)
      lsda_reg <= 1'b1;
    else
      lsda_reg <= sda_in;
  end

  // start and stop show as sda moving during the high phase
  always_comb
  begin
    l_start = lsda_reg & ~sda_in;
    l_stop  = ~lsda_reg & sda_in;
    l_byte  = {l_reg.sh[6:0], lsda_reg};
  end

  // responder: every falling scl edge closes one bit
  always_comb
  begin
    l_next = l_reg;
    unique case (l_reg.st)
      fsa_pkg::L_IDLE:
      begin
        l_next.sda_oe = 1'b0;
      end
      fsa_pkg::L_ADDR:
      begin
        l_next.sh  = l_byte;
        l_next.cnt = l_reg.cnt + 3'h1;
        if (l_reg.cnt == fsa_pkg::LAST_BIT)
        begin
          if (l_byte == {fsa_pkg::ARA_ADDR, 1'b1} && pend_s)
          begin
            l_next.sda_oe = 1'b1;
            l_next.is_ara = 1'b1;
            l_next.st     = fsa_pkg::L_ADDR_ACK;
          end
          else if (l_byte == {addr_s, 1'b0})
          begin
            l_next.sda_oe = 1'b1;
            l_next.is_ara = 1'b0;
            l_next.st     = fsa_pkg::L_ADDR_ACK;
          end
          else
            l_next.st = fsa_pkg::L_IDLE;
        end
      end
      fsa_pkg::L_ADDR_ACK:
      begin
        l_next.cnt = 3'h0;
        if (l_reg.is_ara)
        begin
          // our address in the upper seven bits, low bit left high
          l_next.tx     = {addr_s, 1'b1};
          l_next.sda_oe = ~addr_s[6];
          l_next.st     = fsa_pkg::L_ARA_TX;
        end
        else
        begin
          l_next.sda_oe = 1'b0;
          l_next.st     = fsa_pkg::L_CMD;
        end
      end
      fsa_pkg::L_ARA_TX:
      begin
        // a released one read back low means a lower address is talking
        if (l_reg.tx[7] && !lsda_reg)
        begin
          l_next.sda_oe = 1'b0;
          l_next.st     = fsa_pkg::L_IDLE;
        end
        else if (l_reg.cnt == fsa_pkg::LAST_BIT)
        begin
          l_next.sda_oe = 1'b0;
          l_next.win_t  = ~l_reg.win_t;
          l_next.st     = fsa_pkg::L_ARA_ACK;
        end
        else
        begin
          l_next.tx     = {l_reg.tx[6:0], 1'b1};
          l_next.sda_oe = ~l_reg.tx[6];
          l_next.cnt    = l_reg.cnt + 3'h1;
        end
      end
      fsa_pkg::L_ARA_ACK:
      begin
        l_next.st = fsa_pkg::L_IDLE;
      end
      fsa_pkg::L_CMD:
      begin
        l_next.sh  = l_byte;
        l_next.cnt = l_reg.cnt + 3'h1;
        if (l_reg.cnt == fsa_pkg::LAST_BIT)
        begin
          l_next.is_op = (l_byte == fsa_pkg::CMD_OPERATION);
          if (l_byte == fsa_pkg::CMD_CLEAR)
          begin
            l_next.sda_oe = 1'b1;
            l_next.clr_t  = ~l_reg.clr_t;
            l_next.st     = fsa_pkg::L_CMD_ACK;
          end
          else if (l_byte == fsa_pkg::CMD_OPERATION)
          begin
            l_next.sda_oe = 1'b1;
            l_next.st     = fsa_pkg::L_CMD_ACK;
          end
          else
          begin
            // unknown code: refuse it and report a bus error
            l_next.cml_t = ~l_reg.cml_t;
            l_next.st    = fsa_pkg::L_IDLE;
          end
        end
      end
      fsa_pkg::L_CMD_ACK:
      begin
        l_next.sda_oe = 1'b0;
        l_next.cnt    = 3'h0;
        l_next.st     = l_reg.is_op ? fsa_pkg::L_DATA : fsa_pkg::L_IDLE;
      end
      fsa_pkg::L_DATA:
      begin
        l_next.sh  = l_byte;
        l_next.cnt = l_reg.cnt + 3'h1;
        if (l_reg.cnt == fsa_pkg::LAST_BIT)
        begin
          l_next.op_on  = l_byte[fsa_pkg::OP_ON_BIT];
          l_next.is_op  = 1'b0;
          l_next.sda_oe = 1'b1;
          l_next.st     = fsa_pkg::L_DATA_ACK;
        end
      end
      fsa_pkg::L_DATA_ACK:
      begin
        l_next.sda_oe = 1'b0;
        l_next.st     = fsa_pkg::L_IDLE;
      end
      default:
      begin
        l_next.sda_oe = 1'b0;
        l_next.st     = fsa_pkg::L_IDLE;
      end
    endcase
    // framing beats any bit work; a repeated start restarts the address
    if (l_stop)
    begin
      l_next.sda_oe = 1'b0;
      l_next.st     = fsa_pkg::L_IDLE;
    end
    if (l_start)
    begin
      l_next.sda_oe = 1'b0;
      l_next.cnt    = 3'h0;
      l_next.st     = fsa_pkg::L_ADDR;
    end
  end

  // responder registers change on the falling edge, as the bus expects
  always_ff @(negedge scl or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      l_reg       <= '0;
      l_reg.st    <= fsa_pkg::L_IDLE;
      l_reg.op_on <= fsa_pkg::OP_RST;
    end
    else
    begin
      l_reg <= l_next;
    end
  end

  // outputs, all straight from flip-flops
  assign sda_out    = c_reg.pin_lvl;
  assign sda_oe     = l_reg.sda_oe;
  assign alert1_out = c_reg.pin_lvl;
  assign alert1_oe  = c_reg.a1_oe;
  assign alert2_out = c_reg.pin_lvl;
  assign alert2_oe  = c_reg.a2_oe;
  assign hs_enable  = c_reg.hs_en;
  assign status     = c_reg.status;

endmodule

// file: fsa_pkg.sv
/*
  fsa_pkg: constants and carrier types for the fault, status and alert
  block. Assumes nothing about its users beyond SystemVerilog packages.
*/
package fsa_pkg;

  // status vector bit positions, bits 11 to 14 always read zero
  localparam int B_UV      = 0;
  localparam int B_OV      = 1;
  localparam int B_OC      = 2;
  localparam int B_CML     = 3;
  localparam int B_CURRENT_REGULATION_ACTIVE_WARNING    = 4;
  localparam int B_IOUT_OC = 5;
  localparam int B_IOUT_W2 = 6;
  localparam int B_VIN_UV  = 7;
  localparam int B_VIN_OV  = 8;
  localparam int B_VOUT_UV = 9;
  localparam int B_VOUT_OV = 10;
  localparam int B_FET_BAD = 15;

  // reset values
  localparam logic [15:0] EN1_RST   = 16'h0000;
  localparam logic [15:0] EN2_RST   = 16'h8000;
  localparam logic [15:0] STAT_RST  = 16'h0000;
  localparam logic [11:0] LIM_FULL  = 12'hfff;
  localparam logic [11:0] LIM_ZERO  = 12'h000;
  localparam logic        OP_RST    = 1'b1;

  // bus constants
  localparam logic [6:0] ARA_ADDR      = 7'h0c;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR     = 8'h03;
  localparam int         OP_ON_BIT     = 7;
  localparam logic [2:0] LAST_BIT      = 3'h7;

  // configuration write selects, limits sit at lim[sel - SEL_LIM0]
  localparam logic [2:0] SEL_EN1  = 3'h0;
  localparam logic [2:0] SEL_EN2  = 3'h1;
  localparam logic [2:0] SEL_LIM0 = 3'h2;

  // limit slots
  localparam int L_VIN_OV  = 0;
  localparam int L_VIN_UV  = 1;
  localparam int L_VOUT_OV = 2;
  localparam int L_VOUT_UV = 3;
  localparam int L_IOUT_OC = 4;
  localparam int L_IOUT_W2 = 5;

  // sample channels
  localparam logic [1:0] CH_VIN  = 2'h0;
  localparam logic [1:0] CH_VOUT = 2'h1;
  localparam logic [1:0] CH_IOUT = 2'h2;

  typedef enum logic [3:0] {
    L_IDLE     = 4'h0,
    L_ADDR     = 4'h1,
    L_ADDR_ACK = 4'h2,
    L_ARA_TX   = 4'h3,
    L_ARA_ACK  = 4'h4,
    L_CMD      = 4'h5,
    L_CMD_ACK  = 4'h6,
    L_DATA     = 4'h7,
    L_DATA_ACK = 4'h8
  } fsa_lstate_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  chan;
    logic [11:0] code;
  } fsa_sample_t;

  typedef struct packed {
    logic        wr;
    logic [2:0]  sel;
    logic [15:0] data;
  } fsa_cfg_t;

endpackage

// file: fsa_sync.sv
/*
  fsa_sync: two flip-flop level synchroniser of parameter width.
  Assumes each bit is a level or a toggle that holds for several of the
  destination clock's cycles.
*/
`timescale 1ns/1ps
module fsa_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } fsa_sync_st_t;

  fsa_sync_st_t s_reg;
  fsa_sync_st_t s_next;

  // first stage feeds only the second stage
  always_comb
  begin
    s_next.meta = d;
    s_next.q    = s_reg.meta;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= {INIT, INIT};
    else
      s_reg <= s_next;
  end

  assign q = s_reg.q;

endmodule

// file: fsa_cmp.sv
/*
  fsa_cmp: strict window compare of one converter sample against an
  upper and a lower limit. Assumes the sample is on the caller's clock.
*/
`timescale 1ns/1ps
module fsa_cmp (
  // sample
  input  wire logic        valid,
  input  wire logic [11:0] code,
  // limits
  input  wire logic [11:0] hi,
  input  wire logic [11:0] lo,
  // results
  output logic             over,
  output logic             under
);

  // equality never counts, so a full scale upper or zero scale lower limit never trips
  always_comb
  begin
    over  = valid && (code > hi);
    under = valid && (code < lo);
  end

endmodule

// file: fsa_alert_top_checker.sv
/* fsa_alert_top_checker: port assertions for fsa_alert_top.
   assumes the bind at the foot of this file. */
`timescale 1ns/1ps
module fsa_alert_top_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // watched pins
  input wire logic        ov_fault_in,
  input wire logic        alert1_invert,
  input wire logic        alert2_invert,
  input wire logic        alert1_out,
  input wire logic        alert1_oe,
  input wire logic        alert2_oe,
  input wire logic        sda_out,
  input wire logic        hs_enable,
  input wire logic [15:0] status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // in reset itself the pins must already be released
  a_reset_release: assert property (disable iff (1'b0) !reset_n |->
    !alert1_oe && !alert2_oe) else $error("alert pin held in reset");
  a_fault_off: assert property (|status[2:0] |-> !hs_enable)
    else $error("switch on with a fault latched");
  a_fault_sets: assert property (ov_fault_in [*4] |-> status[1])
    else $error("fault level not latched");
  a_release_together: assert property (!alert1_invert &&
    !alert2_invert && ($fell(alert1_oe) || $fell(alert2_oe))
    |-> !alert1_oe && !alert2_oe)
    else $error("pins released apart");
  // inversion would swap the meaning of the enable
  a_alert_new_bit: assert property (
    !alert1_invert && !alert2_invert && ($rose(alert1_oe) ||
    $rose(alert2_oe)) |-> |(status & ~$past(status)))
    else $error("alert without a newly set bit");
  a_clear_release: assert property (
    !alert1_invert && !alert2_invert &&
    |($past(status) & ~status) && !(|(status & ~$past(status)))
    |-> !alert1_oe && !alert2_oe) else $error("pin kept after clear");
  a_status_unused: assert property (status[14:11] == 4'h0)
    else $error("unused status bits set");
  a_drain_low: assert property (!alert1_out && !sda_out)
    else $error("open drain level not low");
endmodule
bind fsa_alert_top fsa_alert_top_checker i_fsa_alert_top_checker (
  .ref_clk, .reset_n, .ov_fault_in, .alert1_invert, .alert2_invert,
  .alert1_out, .alert1_oe, .alert2_oe, .sda_out, .hs_enable, .status);

// file: fsa_host_model.sv
/* fsa_host_model: serial bus host plus one rival responder.
   assumes a pull-up on sda; scl stands still high between frames. */
`timescale 1ns/1ps
module fsa_host_model (
  // link
  output logic            scl,
  output logic            sda_in,
  input  wire logic       sda_oe,
  // rival responder on the same line
  input  wire logic       rival_on,
  input  wire logic [6:0] rival_addr
);
  logic hl;
  logic rl;
  // wired and; a released line floats high
  assign sda_in = !(hl || rl || sda_oe);
  // idle bus
  initial
  begin
    scl = 1'b1;
    hl = 1'b0;
    rl = 1'b0;
  end
  // one clock, line b before the rise, m after the sample
  task clk(input logic b, input logic m, output logic s);
    hl = !b;
    #16 scl = 1'b1;
    #16 s = sda_in;
    hl = !m;
    #16 scl = 1'b0;
    #16;
  endtask
  // rises that let the link leave reset
  task wake;
    logic s;
    scl = 1'b0;
    repeat (2) clk(1'b1, 1'b1, s);
    scl = 1'b1;
  endtask
  // one byte msb first; rival only answers reads
  task xfer(input logic [7:0] tx, input logic rd, output logic [7:0] rx,
            output logic ack);
    logic [7:0] rv;
    rv = {rival_addr, 1'b1};
    for (int i = 7; i >= 0; i--)
    begin
      rl = rd && rival_on && !rv[i];
      clk(tx[i], tx[i], rx[i]);
    end
    rl = 1'b0;
    clk(1'b1, 1'b1, ack);
    ack = !ack;
  endtask
  // start, n bytes from the top of b, stop
  task frame(input logic [23:0] b, input int n, output logic ok);
    logic [7:0] x;
    logic k;
    scl = 1'b0;
    clk(1'b1, 1'b0, k);
    ok = 1'b1;
    for (int j = 0; j < n; j++)
    begin
      xfer(b[23-8*j -: 8], 1'b0, x, k);
      ok = ok & k;
    end
    clk(1'b0, 1'b1, k);
    scl = 1'b1;
  endtask
  // response read, host answers the data with a nack
  task ara(output logic [7:0] d, output logic ok);
    logic k;
    scl = 1'b0;
    clk(1'b1, 1'b0, k);
    xfer({fsa_pkg::ARA_ADDR, 1'b1}, 1'b0, d, ok);
    xfer(8'hff, 1'b1, d, k);
    clk(1'b0, 1'b1, k);
    scl = 1'b1;
  endtask
endmodule

// file: fsa_alert_top_tb_top.sv
/* fsa_alert_top_tb_top: directed bench for fsa_alert_top.
   assumes fsa_host_model as the host; inversion is bench driven. */
`timescale 1ns/1ps
module fsa_alert_top_tb_top;
  `define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    err_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
  logic                 ref_clk, reset_n, scl, sda_in, sda_out, sda_oe;
  logic                 fet, current_regulation_active_warning, vsense, a1o, a1e, a2o, a2e, hs, ack;
  logic                 rival_on, w2o, inv;
  logic [2:0]           flt;
  logic [6:0]           own_addr = 7'h50;
  logic [7:0]           d;
  logic [15:0]          status;
  fsa_pkg::fsa_sample_t sample;
  fsa_pkg::fsa_cfg_t    cfg;
  int                   err_count, samples_checked;
  fsa_alert_top i_fsa_alert_top (.ref_clk, .reset_n, .scl, .sda_in,
    .sda_out, .sda_oe, .own_addr, .uv_fault_in(flt[0]),
    .ov_fault_in(flt[1]), .oc_timeout_in(flt[2]),
    .hs_timer_active_in(current_regulation_active_warning), .fet_health_bad_in(fet), .sample, .cfg,
    .has_vout_sense(vsense), .warn2_over(w2o), .alert1_invert(inv),
    .alert2_invert(inv), .alert1_out(a1o), .alert1_oe(a1e),
    .alert2_out(a2o), .alert2_oe(a2e), .hs_enable(hs), .status);
  fsa_host_model i_fsa_host_model (.scl, .sda_in, .sda_oe, .rival_on,
    .rival_addr(7'h20));
  // core clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task put_sample(input logic [11:0] c,
                  input logic [1:0]  ch = fsa_pkg::CH_VOUT);
    sample = {1'b1, ch, c};
    tick(1);
    sample.valid = 1'b0;
    tick(1);
  endtask
  // one configuration write, then a quiet cycle before the next
  task put_cfg(input logic [2:0] s, input logic [15:0] v);
    cfg = {1'b1, s, v};
    tick(1);
    cfg.wr = 1'b0;
    tick(1);
  endtask
  // link tasks end off the clock, so realign; clear lands 3 cycles on
  task send(input logic [15:0] cv, input int n);
    i_fsa_host_model.frame({own_addr, 1'b0, cv}, n, ack);
    tick(4);
  endtask
  task ara;
    i_fsa_host_model.ara(d, ack);
    tick(4);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #300000;
    err_count++;
    complete_run;
  end
  // main sequence
  initial
  begin
    {reset_n, flt, fet, current_regulation_active_warning, rival_on, w2o, inv, sample, cfg} = '0;
    vsense = 1'b1;
    tick(3);
    reset_n = 1'b1;
    `CHK("status", 16'h0000, status)
    `CHK("pins", 2'b00, {a1e, a2e})
    i_fsa_host_model.wake;
    tick(2);
    fet = 1'b1;
    tick(4);
    `CHK("alert2", 2'b01, {a1e, a2e})
    `CHK("drain", 3'b000, {a1o, a2o, sda_out})
    send({fsa_pkg::CMD_CLEAR, 8'h00}, 2);
    `CHK("persist", 2'b10, {status[15], a2e})
    fet = 1'b0;
    send({fsa_pkg::CMD_CLEAR, 8'h00}, 2);
    `CHK("fet bit", 1'b0, status[15])
    current_regulation_active_warning = 1'b1;
    tick(4);
    `CHK("warning", 2'b11, {status[4], hs})
    current_regulation_active_warning = 1'b0;
    // each fault stops the switch until an off then on cycle
    for (int f = 0; f < 3; f++)
    begin
      flt = 3'h1 << f;
      tick(4);
      `CHK("fault", 2'b10, {status[f], hs})
      flt = 3'h0;
      send({fsa_pkg::CMD_OPERATION, 8'h00}, 3);
      send({fsa_pkg::CMD_OPERATION, 8'h80}, 3);
      `CHK("restart", 2'b01, {status[f], hs})
    end
    cfg = {1'b1, fsa_pkg::SEL_EN1, 16'h0200};
    tick(1);
    cfg = {1'b1, 3'h5, 16'h0100};
    tick(1);
    cfg.wr = 1'b0;
    put_sample(12'h100);
    `CHK("equal", 1'b0, status[9])
    put_sample(12'h0ff);
    `CHK("under", 2'b11, {status[9], a1e})
    rival_on = 1'b1;
    ara;
    `CHK("rival", {7'h20, 1'b1}, {d[7:1], a1e})
    rival_on = 1'b0;
    ara;
    `CHK("addr", {own_addr, 1'b1}, {d[7:1], ack})
    `CHK("answered", 2'b10, {status[9], a1e})
    put_sample(12'h0ff);
    `CHK("no retrigger", 1'b0, a1e)
    send({fsa_pkg::CMD_CLEAR, 8'h00}, 2);
    put_sample(12'h0ff);
    `CHK("next sample", 1'b1, a1e)
    send({fsa_pkg::CMD_CLEAR, 8'h00}, 2);
    vsense = 1'b0;
    put_sample(12'h0ff);
    `CHK("no sense", 1'b0, status[9])
    send({8'h55, 8'h00}, 2);
    `CHK("bad cmd", 1'b1, status[3])
    // other converter channels, second threshold in both polarities
    put_cfg(3'h2, 16'h0800);
    put_cfg(3'h7, 16'h0100);
    put_sample(12'h800, fsa_pkg::CH_VIN);
    `CHK("vin equal", 1'b0, status[8])
    put_sample(12'h801, fsa_pkg::CH_VIN);
    put_sample(12'h0ff, fsa_pkg::CH_IOUT);
    `CHK("vin iout", 3'b110, {status[8], status[6:5]})
    send({fsa_pkg::CMD_CLEAR, 8'h00}, 2);
    w2o = 1'b1;
    put_sample(12'h0ff, fsa_pkg::CH_IOUT);
    `CHK("w2 polarity", 1'b0, status[6])
    put_sample(12'h101, fsa_pkg::CH_IOUT);
    `CHK("w2 over", 1'b1, status[6])
    // inversion turns an idle pin into a driven one
    inv = 1'b1;
    tick(2);
    `CHK("invert", 2'b11, {a1e, a2e})
    inv = 1'b0;
    tick(2);
    `CHK("invert off", 2'b00, {a1e, a2e})
    complete_run;
  end
endmodule
